/* verilog/osc_enable_and_settle_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module osc_enable_and_settle_monitor
	import osc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire reg_addr_t regAddr,
	input wire logic regWrByte,
	input wire logic regWrBit,
	input wire bit_idx_t regBitIdx,
	input wire logic regBitVal,
	input wire byte_t regWdata,
	input wire logic regRd,
	input wire logic extClkSel,
	input wire logic mainPinOscSel,
	input wire logic subPinOscSel,
	input wire logic [2:0] settleSelect,
	input wire logic oscToggling,
	input wire logic deepHaltEnter,
	input wire logic deepHaltRelease,
	input wire logic cpuClkIsSub,
	input wire logic mainClkIsExt,
	output byte_t regRdata_q,
	output logic regRdValid_q,
	output logic mainOscEnable_q,
	output logic mainExtClkEnable_q,
	output logic subOscEnable_q,
	output logic fastRcEnable_q,
	output logic settleDone_q,
	output logic haltMisuse_q
);

	localparam int SETTLE_EXP [`SETTLE_FLAGS] = '{
		`SETTLE_EXP0, `SETTLE_EXP1, `SETTLE_EXP2, `SETTLE_EXP3,
		`SETTLE_EXP4, `SETTLE_EXP5, `SETTLE_EXP6, `SETTLE_EXP7
	};

	logic runSel;
	logic statSel;
	logic runByteWr;
	logic runBitWr;

	logic mainHaltWritten;
	logic mainHaltNext;
	logic mainHalt_q;
	logic subHaltWritten;
	logic subHaltNext;
	logic subHalt_q;
	logic fastRcHaltWritten;
	logic fastRcHaltNext;
	logic fastRcHalt_q;

	logic oscMode;
	logic extMode;
	logic settleClear;
	logic settleStart;
	logic coreOnHighSpeed;
	logic coreOnFastRc;
	logic misuse;

	settle_state_e state_q;
	settle_state_e state_d;
	settle_cnt_t cnt_q;
	settle_cnt_t cnt_d;
	settle_cnt_t limit;
	logic atLimit;
	logic [`SETTLE_FLAGS-1:0] flagAsc;
	byte_t runValue;
	byte_t statValue;

	function automatic settle_cnt_t settleLimit(input logic [2:0] sel);
		settle_cnt_t lim;
		lim = settle_cnt_t'(0);
		unique case (sel)
			3'h0: lim = settle_cnt_t'(1) << `SETTLE_EXP0;
			3'h1: lim = settle_cnt_t'(1) << `SETTLE_EXP1;
			3'h2: lim = settle_cnt_t'(1) << `SETTLE_EXP2;
			3'h3: lim = settle_cnt_t'(1) << `SETTLE_EXP3;
			3'h4: lim = settle_cnt_t'(1) << `SETTLE_EXP4;
			3'h5: lim = settle_cnt_t'(1) << `SETTLE_EXP5;
			3'h6: lim = settle_cnt_t'(1) << `SETTLE_EXP6;
			3'h7: lim = settle_cnt_t'(1) << `SETTLE_EXP7;
		endcase
		return lim;
	endfunction : settleLimit

	// Address decode; writes to the status word fall on no register.
	assign runSel = (regAddr == `OSC_RUN_CTRL_ADDR);
	assign statSel = (regAddr == `OSC_SETTLE_STAT_ADDR);
	assign runByteWr = regWrByte & runSel;
	assign runBitWr = regWrBit & runSel;

	osc_run_bit #(
		.BIT_POS(`RUN_MAIN_HALT_BIT),
		.RST_VAL(1'(`OSC_RUN_CTRL_RST >> `RUN_MAIN_HALT_BIT))
	) u_main_halt (
		.mclk(mclk),
		.reset_n(reset_n),
		.byteWr(runByteWr),
		.bitWr(runBitWr),
		.bitIdx(regBitIdx),
		.bitVal(regBitVal),
		.wdata(regWdata),
		.written(mainHaltWritten),
		.nextVal(mainHaltNext),
		.value_q(mainHalt_q)
	);

	osc_run_bit #(
		.BIT_POS(`RUN_SUB_HALT_BIT),
		.RST_VAL(1'(`OSC_RUN_CTRL_RST >> `RUN_SUB_HALT_BIT))
	) u_sub_halt (
		.mclk(mclk),
		.reset_n(reset_n),
		.byteWr(runByteWr),
		.bitWr(runBitWr),
		.bitIdx(regBitIdx),
		.bitVal(regBitVal),
		.wdata(regWdata),
		.written(subHaltWritten),
		.nextVal(subHaltNext),
		.value_q(subHalt_q)
	);

	osc_run_bit #(
		.BIT_POS(`RUN_FAST_RC_HALT_BIT),
		.RST_VAL(1'(`OSC_RUN_CTRL_RST >> `RUN_FAST_RC_HALT_BIT))
	) u_fast_rc_halt (
		.mclk(mclk),
		.reset_n(reset_n),
		.byteWr(runByteWr),
		.bitWr(runBitWr),
		.bitIdx(regBitIdx),
		.bitVal(regBitVal),
		.wdata(regWdata),
		.written(fastRcHaltWritten),
		.nextVal(fastRcHaltNext),
		.value_q(fastRcHalt_q)
	);

	assign oscMode = ~extClkSel & mainPinOscSel;
	assign extMode = extClkSel & mainPinOscSel;

	// Oscillator enables. The 20 MHz and low-speed oscillators are not driven here.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			mainOscEnable_q <= 1'b0;
			mainExtClkEnable_q <= 1'b0;
		end else begin
			mainOscEnable_q <= ~mainHalt_q & oscMode;
			mainExtClkEnable_q <= ~mainHalt_q & extMode;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			subOscEnable_q <= 1'b0;
		end else begin
			subOscEnable_q <= ~subHalt_q & subPinOscSel;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			fastRcEnable_q <= 1'b1;
		end else begin
			fastRcEnable_q <= ~fastRcHalt_q;
		end
	end

	// Hardware does not refuse a halt of the running core clock; it only records it.
	assign coreOnHighSpeed = ~cpuClkIsSub & mainClkIsExt;
	assign coreOnFastRc = ~cpuClkIsSub & ~mainClkIsExt;

	always_comb begin
		misuse = 1'b0;
		if (mainHaltWritten && mainHaltNext && coreOnHighSpeed) begin
			misuse = 1'b1;
		end
		if (subHaltWritten && subHaltNext && cpuClkIsSub) begin
			misuse = 1'b1;
		end
		if (fastRcHaltWritten && fastRcHaltNext && coreOnFastRc) begin
			misuse = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			haltMisuse_q <= 1'b0;
		end else begin
			haltMisuse_q <= haltMisuse_q | misuse;
		end
	end

	// Clear and start events of the settle counter.
	assign settleClear = deepHaltEnter | (mainHaltWritten & mainHaltNext);
	assign settleStart = deepHaltRelease | (mainHaltWritten & mainHalt_q & ~mainHaltNext & oscMode);

	assign limit = settleLimit(settleSelect);
	assign atLimit = (cnt_q >= limit);

	// A clear takes priority over a start in the same cycle, since a halted
	// oscillator cannot be settling.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			SETTLE_IDLE: begin
				if (settleStart) begin
					state_d = SETTLE_ARMED;
				end
			end
			SETTLE_ARMED: begin
				if (oscToggling) begin
					state_d = SETTLE_COUNT;
				end
			end
			SETTLE_COUNT: begin
				if (atLimit) begin
					state_d = SETTLE_DONE;
				end
			end
			SETTLE_DONE: begin
				if (settleStart) begin
					state_d = SETTLE_ARMED;
				end
			end
		endcase
		if (settleClear) begin
			state_d = SETTLE_IDLE;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_q <= SETTLE_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_comb begin
		cnt_d = cnt_q;
		if (settleClear || settleStart) begin
			cnt_d = settle_cnt_t'(0);
		end else if ((state_q == SETTLE_ARMED || state_q == SETTLE_COUNT) && oscToggling && !atLimit) begin
			cnt_d = cnt_q + settle_cnt_t'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			cnt_q <= settle_cnt_t'(0);
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			settleDone_q <= 1'b0;
		end else begin
			settleDone_q <= (state_d == SETTLE_DONE);
		end
	end

	// Flags watch the next count, so a clear lowers them even while the count stands past their threshold.
	genvar gi;
	generate
		for (gi = 0; gi < `SETTLE_FLAGS; gi++) begin : g_flag
			settle_flag_cell #(
				.EXP(SETTLE_EXP[gi])
			) u_flag (
				.mclk(mclk),
				.reset_n(reset_n),
				.count(cnt_d),
				.clear(settleClear),
				.flag_q(flagAsc[gi])
			);
		end
	endgenerate

	// The shortest time sits in bit 7, so the word fills from the top down.
	always_comb begin
		statValue = `OSC_SETTLE_STAT_RST;
		for (int i = 0; i < `SETTLE_FLAGS; i++) begin
			statValue[`SETTLE_FLAGS-1-i] = flagAsc[i];
		end
	end

	always_comb begin
		runValue = `OSC_RUN_CTRL_RST & `OSC_RUN_CTRL_MASK;
		runValue[`RUN_MAIN_HALT_BIT] = mainHalt_q;
		runValue[`RUN_SUB_HALT_BIT] = subHalt_q;
		runValue[`RUN_FAST_RC_HALT_BIT] = fastRcHalt_q;
		runValue = runValue & `OSC_RUN_CTRL_MASK;
	end

	// Reads answer one cycle later; a bit read returns the whole byte.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			regRdValid_q <= 1'b0;
			regRdata_q <= `OSC_UNMAPPED_READ;
		end else begin
			regRdValid_q <= regRd;
			if (!regRd) begin
				regRdata_q <= `OSC_UNMAPPED_READ;
			end else if (runSel) begin
				regRdata_q <= runValue;
			end else if (statSel) begin
				regRdata_q <= statValue;
			end else begin
				regRdata_q <= `OSC_UNMAPPED_READ;
			end
		end
	end

endmodule : osc_enable_and_settle_monitor
`default_nettype wire

/* verilog/osc_map.svh */
// Notes on behaviour
// - Run control resets to C0 hex.
// - Run control takes bit and byte writes, readable.
// - Bit 7 halts main crystal or external clock.
// - Bit 6 halts the subsystem crystal oscillator.
// - Bit 0 halts only the fast RC oscillator.
// - Run control bits 5 to 1 read zero.
// - Settle status is read-only, bit or byte reads.
// - Status clears on reset, deep halt, main halt.
// - Counting starts on main crystal start or deep-halt release.
// - Flags set in order and stay set.
// - Counter stops at the selected settle limit.
// - Only cycles after oscillation starts are counted.
// - Settle select codes pick the eight limits.
// - cpu_clk_is_sub shows core on subsystem clock.
// - Pin modes: crystal, external clock or port.
`ifndef OSC_MAP_SVH
`define OSC_MAP_SVH

`define OSC_ADDR_W 20
`define OSC_RUN_CTRL_ADDR 20'hFFFA1
`define OSC_SETTLE_STAT_ADDR 20'hFFFA2
`define OSC_RUN_CTRL_RST 8'hC0
`define OSC_SETTLE_STAT_RST 8'h00
`define OSC_RUN_CTRL_MASK 8'hC1
`define OSC_UNMAPPED_READ 8'h00
`define RUN_MAIN_HALT_BIT 7
`define RUN_SUB_HALT_BIT 6
`define RUN_FAST_RC_HALT_BIT 0
`define SETTLE_CNT_W 19
`define SETTLE_FLAGS 8
`define SETTLE_EXP0 8
`define SETTLE_EXP1 9
`define SETTLE_EXP2 10
`define SETTLE_EXP3 11
`define SETTLE_EXP4 13
`define SETTLE_EXP5 15
`define SETTLE_EXP6 17
`define SETTLE_EXP7 18

`endif

/* verilog/osc_pkg.sv */
`default_nettype none
package osc_pkg;
`include "osc_map.svh"

	typedef logic [2:0] bit_idx_t;
	typedef logic [7:0] byte_t;
	typedef logic [`OSC_ADDR_W-1:0] reg_addr_t;
	typedef logic [`SETTLE_CNT_W-1:0] settle_cnt_t;
	typedef enum logic [1:0] {
		SETTLE_IDLE = 2'b00,
		SETTLE_ARMED = 2'b01,
		SETTLE_COUNT = 2'b11,
		SETTLE_DONE = 2'b10
	} settle_state_e;

endpackage : osc_pkg
`default_nettype wire

/* verilog/osc_run_bit.sv */
`timescale 1ns/1ps
`default_nettype none
module osc_run_bit
	import osc_pkg::*;
#(
	parameter int BIT_POS = 0,
	parameter logic RST_VAL = 1'b0
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic byteWr,
	input wire logic bitWr,
	input wire bit_idx_t bitIdx,
	input wire logic bitVal,
	input wire byte_t wdata,
	output logic written,
	output logic nextVal,
	output logic value_q
);

	always_comb begin
		written = byteWr | (bitWr && (bitIdx == bit_idx_t'(BIT_POS)));
		if (byteWr) begin
			nextVal = wdata[BIT_POS];
		end else if (written) begin
			nextVal = bitVal;
		end else begin
			nextVal = value_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			value_q <= RST_VAL;
		end else begin
			value_q <= nextVal;
		end
	end

endmodule : osc_run_bit
`default_nettype wire

/* verilog/settle_flag_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module settle_flag_cell
	import osc_pkg::*;
#(
	parameter int EXP = 8
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire settle_cnt_t count,
	input wire logic clear,
	output logic flag_q
);

	localparam settle_cnt_t THRESHOLD = settle_cnt_t'(1) << EXP;

	logic reached;

	assign reached = (count >= THRESHOLD);

	// A reached threshold beats a clear in the same cycle, so no event is lost.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= reached | (flag_q & ~clear);
		end
	end

endmodule : settle_flag_cell
`default_nettype wire

/* dv/osc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module osc_model #(
	parameter int START_DELAY = 20
) (
	input wire logic mclk,
	input wire logic enable,
	output logic oscToggling
);
	// A resonator needs time to build up, so toggling lags the enable.
	// The block must not count that lag.
	int waitCnt = 0;
	always @(posedge mclk) begin
		if (enable !== 1'b1) begin
			waitCnt <= 0;
			oscToggling <= 1'b0;
		end else if (waitCnt < START_DELAY) begin
			waitCnt <= waitCnt + 1;
		end else begin
			oscToggling <= 1'b1;
		end
	end
endmodule : osc_model
`default_nettype wire

/* dv/osc_enable_and_settle_monitor_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "osc_map.svh"
module osc_checker
	import osc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire reg_addr_t regAddr,
	input wire logic regWrByte,
	input wire logic regWrBit,
	input wire byte_t regWdata,
	input wire logic regRd,
	input wire logic subPinOscSel,
	input wire logic [2:0] settleSelect,
	input wire logic deepHaltEnter,
	input wire logic deepHaltRelease,
	input wire byte_t regRdata_q,
	input wire logic regRdValid_q,
	input wire logic mainOscEnable_q,
	input wire logic mainExtClkEnable_q,
	input wire logic subOscEnable_q,
	input wire logic fastRcEnable_q,
	input wire logic settleDone_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_wrRun;
		regWrByte && regAddr == `OSC_RUN_CTRL_ADDR;
	endsequence
	sequence s_quiet;
		!regWrByte && !regWrBit;
	endsequence
	property p_rdValid; regRd |=> regRdValid_q; endproperty
	a_rdValid: assert property (p_rdValid) else $error("read not answered");
	property p_rdIdle; !regRd |=> !regRdValid_q && regRdata_q == 8'h00; endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data without read");
	property p_unused; regRd && regAddr == `OSC_RUN_CTRL_ADDR |=> regRdata_q[5:1] == 5'h00; endproperty
	a_unused: assert property (p_unused) else $error("unused bits not zero");
	property p_fast; s_wrRun ##0 !regWdata[0] ##1 s_quiet |=> fastRcEnable_q; endproperty
	a_fast: assert property (p_fast) else $error("fast RC not running");
	property p_halt; s_wrRun ##0 regWdata[7] ##1 s_quiet |=> !mainOscEnable_q && !mainExtClkEnable_q; endproperty
	a_halt: assert property (p_halt) else $error("main clock not halted");
	property p_clear; s_wrRun ##0 regWdata[7] |-> ##[1:3] !settleDone_q; endproperty
	a_clear: assert property (p_clear) else $error("halt did not clear settle");
	property p_deep; deepHaltEnter |-> ##[1:3] !settleDone_q; endproperty
	a_deep: assert property (p_deep) else $error("deep halt did not clear settle");
	property p_mode; mainOscEnable_q |-> !mainExtClkEnable_q; endproperty
	a_mode: assert property (p_mode) else $error("crystal and external both on");
	property p_sub; subOscEnable_q |-> $past(subPinOscSel); endproperty
	a_sub: assert property (p_sub) else $error("sub oscillator on in port mode");
	property p_hold;
		settleDone_q && !regWrByte && !regWrBit && !deepHaltEnter && !deepHaltRelease && $stable(settleSelect)
			|=> settleDone_q;
	endproperty
	a_hold: assert property (p_hold) else $error("settle done dropped");
endmodule : osc_checker
bind osc_enable_and_settle_monitor osc_checker i_osc_checker (.mclk, .reset_n, .regAddr, .regWrByte, .regWrBit,
	.regWdata, .regRd, .subPinOscSel, .settleSelect, .deepHaltEnter, .deepHaltRelease, .regRdata_q, .regRdValid_q,
	.mainOscEnable_q, .mainExtClkEnable_q, .subOscEnable_q, .fastRcEnable_q, .settleDone_q);
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "osc_map.svh"
module tb_top
	import osc_pkg::*;
;
	localparam reg_addr_t runA = `OSC_RUN_CTRL_ADDR;
	localparam reg_addr_t statA = `OSC_SETTLE_STAT_ADDR;
	logic mclk = 0, reset_n = 0, regWrByte = 0, regWrBit = 0, regBitVal = 0, regRd = 0;
	logic extClkSel = 0, mainPinOscSel = 1, subPinOscSel = 1, deepHaltEnter = 0, deepHaltRelease = 0;
	logic [2:0] settleSelect = 3'h1;
	reg_addr_t regAddr = '0;
	bit_idx_t regBitIdx = '0;
	byte_t regWdata = '0, regRdata_q;
	logic regRdValid_q, mainOscEnable_q, mainExtClkEnable_q, subOscEnable_q, fastRcEnable_q;
	logic settleDone_q, haltMisuse_q, oscToggling;
	logic cpuClkIsSub = 0, mainClkIsExt = 0;
	int nMismatch = 0, samplesChecked = 0, cycles = 0;
	byte_t wv [6] = '{8'h00, 8'hFF, 8'h3E, 8'h40, 8'h01, 8'hC1};
	byte_t ev [6] = '{8'h00, 8'hC1, 8'h00, 8'h40, 8'h01, 8'hC1};
	osc_enable_and_settle_monitor i_osc_enable_and_settle_monitor (.mclk, .reset_n, .regAddr, .regWrByte, .regWrBit,
		.regBitIdx, .regBitVal, .regWdata, .regRd, .extClkSel, .mainPinOscSel, .subPinOscSel, .settleSelect,
		.oscToggling, .deepHaltEnter, .deepHaltRelease, .cpuClkIsSub, .mainClkIsExt, .regRdata_q,
		.regRdValid_q, .mainOscEnable_q, .mainExtClkEnable_q, .subOscEnable_q, .fastRcEnable_q, .settleDone_q,
		.haltMisuse_q);
	osc_model i_osc_model (.mclk, .enable(mainOscEnable_q | mainExtClkEnable_q), .oscToggling);
	initial begin
		forever #5 mclk = ~mclk;
	end
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	task automatic check(input byte_t seen, input byte_t exp);
		samplesChecked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input reg_addr_t a, input byte_t d);
		@(negedge mclk);
		regAddr = a;
		regWdata = d;
		regWrByte = 1;
		@(negedge mclk);
		regWrByte = 0;
	endtask : wr
	task automatic wb(input bit_idx_t i, input logic v);
		@(negedge mclk);
		regAddr = runA;
		regBitIdx = i;
		regBitVal = v;
		regWrBit = 1;
		@(negedge mclk);
		regWrBit = 0;
	endtask : wb
	task automatic pulse_reset;
		@(negedge mclk);
		reset_n = 0;
		repeat (3) @(negedge mclk);
		reset_n = 1;
	endtask : pulse_reset
	task automatic rdc(input reg_addr_t a, input byte_t e);
		@(negedge mclk);
		regAddr = a;
		regRd = 1;
		@(negedge mclk);
		regRd = 0;
		check({7'h00, regRdValid_q}, 8'h01);
		check(regRdata_q, e);
	endtask : rdc
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 4000) begin
			nMismatch++;
			stop_test();
		end
	end
	initial begin
		repeat (3) @(negedge mclk);
		reset_n = 1;
		rdc(runA, 8'hC0);
		rdc(statA, 8'h00);
		check({4'h0, fastRcEnable_q, subOscEnable_q, mainOscEnable_q, haltMisuse_q}, 8'h08);
		for (int k = 0; k < 6; k++) begin
			wr(runA, wv[k]);
			@(negedge mclk);
			rdc(runA, ev[k]);
			check({5'h00, fastRcEnable_q, subOscEnable_q, mainOscEnable_q}, {5'h00, ~ev[k][0], ~ev[k][6], ~ev[k][7]});
		end
		// The all-ones row stopped the fast RC while it fed the core.
		check({7'h00, haltMisuse_q}, 8'h01);
		wb(3'h3, 1'b1);
		wb(3'h0, 1'b0);
		rdc(runA, 8'hC0);
		wr(statA, 8'hFF);
		rdc(statA, 8'h00);
		rdc(20'h12345, 8'h00);
		wr(runA, 8'h00);
		repeat (262) @(negedge mclk);
		rdc(statA, 8'h00);
		repeat (40) @(negedge mclk);
		rdc(statA, 8'h80);
		repeat (400) @(negedge mclk);
		rdc(statA, 8'hC0);
		check({7'h00, settleDone_q}, 8'h01);
		@(negedge mclk);
		deepHaltEnter = 1;
		@(negedge mclk);
		deepHaltEnter = 0;
		rdc(statA, 8'h00);
		deepHaltRelease = 1;
		@(negedge mclk);
		deepHaltRelease = 0;
		repeat (600) @(negedge mclk);
		rdc(statA, 8'hC0);
		wb(3'h7, 1'b1);
		rdc(statA, 8'h00);
		check({7'h00, mainOscEnable_q}, 8'h00);
		extClkSel = 1;
		wr(runA, 8'h00);
		@(negedge mclk);
		check({6'h00, mainExtClkEnable_q, mainOscEnable_q}, 8'h02);
		// A main start in external clock mode does not arm the settle counter; only a deep-halt release would.
		repeat (300) @(negedge mclk);
		rdc(statA, 8'h00);
		// A reset in mid-run brings back every reset value, the sticky misuse flag too.
		pulse_reset();
		check({4'h0, fastRcEnable_q, subOscEnable_q, mainOscEnable_q, haltMisuse_q}, 8'h08);
		rdc(runA, 8'hC0);
		cpuClkIsSub = 1;
		wr(runA, 8'h81);
		@(negedge mclk);
		check({7'h00, haltMisuse_q}, 8'h00);
		wb(3'h6, 1'b1);
		@(negedge mclk);
		check({7'h00, haltMisuse_q}, 8'h01);
		pulse_reset();
		cpuClkIsSub = 0;
		mainClkIsExt = 1;
		wb(3'h0, 1'b1);
		wb(3'h7, 1'b0);
		@(negedge mclk);
		check({7'h00, haltMisuse_q}, 8'h00);
		wb(3'h7, 1'b1);
		@(negedge mclk);
		check({7'h00, haltMisuse_q}, 8'h01);
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
